// [evt_monitor_defs.svh]
// Register indices, field positions, reset values and bus codes
`ifndef EVT_MONITOR_DEFS_SVH
`define EVT_MONITOR_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_IO_UPDATE 12'h005
`define IDX_MASK_BASE 12'h209
`define IDX_MASK_LAST 12'h20f
`define IDX_CLEAR_ALL 12'ha03
`define IDX_CLEAR_BASE 12'ha04
`define IDX_CLOCK_EVT 12'hd02
`define IDX_LOADER_EVT 12'hd03
`define IDX_LOOP_EVT 12'hd04
`define IDX_LIMITER_EVT 12'hd05
`define IDX_REF_AB_EVT 12'hd06
`define IDX_REF_CD_EVT 12'hd07
`define IDX_LOOP_SNAP 12'hd08
`define IDX_LOOP_SNAP_TWO 12'hd09
`define IDX_RSVD_SLOT 12'hd0a

// Implemented bits of each event register
`define VALID_CLOCK_EVT 8'h3f
`define VALID_LOADER_EVT 8'h1f
`define VALID_LOOP_EVT 8'hff
`define VALID_LIMITER_EVT 8'h1f
`define VALID_REF_EVT 8'h77

// Field positions and command values
`define BIT_CLEAR_ALL 1
`define IO_UPDATE_CMD 8'h01

// Reset values
`define RST_FLAGS 8'h00
`define RST_MASK 8'h00
`define RST_SNAP 8'h00

// Bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// [evt_monitor_pkg.sv]
// Types shared by the event monitor
package evt_monitor_pkg;
    typedef logic [7:0] reg8_t;
    typedef logic [1:0] axi_resp_t;
    typedef logic [11:0] reg_idx_t;
endpackage

// [loop_state_event_flags_status.sv]
// Sticky event flags and loop status snapshot behind an AXI4-Lite slave
//
// Behaviour
// R01: An unmasked event sets its flag, which then stays set.
// R02: Flags clear only by clear registers, clear-all bit or reset; reads never clear.
// R03: Clock events bit 5 system PLL lost lock, bit 4 gained lock; 7:6 reserved.
// R04: Clock events bit 3 output analog PLL lost lock, bit 2 gained lock.
// R05: Clock events bit 1 calibration ended, bit 0 calibration began.
// R06: Loader events bit 4 ROM load done, bit 3 distribution sync; 7:5 reserved.
// R07: Loader events bit 2 sets on each watchdog expiry.
// R08: Loader events bit 1 EEPROM fault, bit 0 EEPROM load or save done.
// R09: Loop events bits 7..4: switching, closed loop, free run, holdover.
// R10: Loop events bits 3/2 frequency lock lost/gained, 1/0 phase lock lost/gained.
// R11: Limiter events bit 4 history update; bits 7:5 reserved.
// R12: Limiter events bit 3 leaves clamp, bit 2 enters clamp.
// R13: Limiter events bit 1 slew limiting stops, bit 0 starts.
// R14: Per reference validated, fault cleared, faulted; A/C bits 2:0, B/D 6:4.
// R15: Snapshot bit 6 offset rate limited, 5 frequency lock, 4 phase lock.
// R16: Snapshot bit 3 switchover, 2 holdover, 1 closed loop, 0 free run.
// R17: Second snapshot bit 5 clamp in effect, bit 4 history available.
// R18: Second snapshot bits 3:2 active reference priority, 00 highest.
// R19: Second snapshot bits 1:0 active reference index, A=00 to D=11.
// R20: Snapshots refresh only when 0x01 is written to the update register.
// R21: Status range is read-only; event flags read live.
// R22: Event in the same cycle as its clear leaves the flag set.
`include "evt_monitor_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module loop_state_event_flags_status #(
    parameter int ADDR_WIDTH = 14
) (
    input wire logic sys_clk,
    input wire logic reset,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Event pulses, one bit per event, high for one cycle per event
    input wire logic [7:0] clockEvents,
    input wire logic [7:0] loaderEvents,
    input wire logic [7:0] loopEvents,
    input wire logic [7:0] limiterEvents,
    input wire logic [7:0] refAbEvents,
    input wire logic [7:0] refCdEvents,
    // Live digital_loop state, sampled on I/O update
    input wire logic offsetSlewLimited,
    input wire logic freqLocked,
    input wire logic phaseLocked,
    input wire logic refSwitching,
    input wire logic inHoldover,
    input wire logic closedLoopActive,
    input wire logic inFreeRun,
    input wire logic tuningClamped,
    input wire logic historyAvailable,
    input wire logic [1:0] activeRefPriority,
    input wire logic [1:0] activeRefIndex
);

    localparam int NUM_EVT = 6;
    localparam int IDX_W = 12;

    ////////////////////////////////////////////////////////////////////////
    // Write channel capture

    logic awHeld_q;
    logic wHeld_q;
    logic [ADDR_WIDTH-1:0] awAddr_q;
    logic [7:0] wByte_q;
    logic wLane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic doWrite;
    logic awTake;
    logic wTake;

    // Address and data may arrive in either order
    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready = !wHeld_q && !bvalid_q;
    assign awTake = s_axi_awvalid && s_axi_awready;
    assign wTake = s_axi_wvalid && s_axi_wready;
    assign doWrite = awHeld_q && wHeld_q && !bvalid_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (awTake) begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    // Only the low byte lane carries register data
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            wHeld_q <= 1'b0;
            wByte_q <= 8'h00;
            wLane_q <= 1'b0;
        end else if (wTake) begin
            wHeld_q <= 1'b1;
            wByte_q <= s_axi_wdata[7:0];
            wLane_q <= s_axi_wstrb[0];
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode

    evt_monitor_pkg::reg_idx_t wrIdx;
    logic wrEn;
    logic wrMask;
    logic wrClear;
    logic wrClearAll;
    logic wrUpdate;
    logic clearAll;
    logic ioUpdate;

    assign wrIdx = awAddr_q[IDX_W+1:2];
    assign wrEn = doWrite && wLane_q;
    assign wrMask = (wrIdx >= `IDX_MASK_BASE) && (wrIdx <= `IDX_MASK_LAST);
    assign wrClear = (wrIdx >= `IDX_CLEAR_BASE)
        && (wrIdx < `IDX_CLEAR_BASE + 12'(NUM_EVT));
    assign wrClearAll = (wrIdx == `IDX_CLEAR_ALL);
    assign wrUpdate = (wrIdx == `IDX_IO_UPDATE);
    assign clearAll = wrEn && wrClearAll && wByte_q[`BIT_CLEAR_ALL]; // R02
    assign ioUpdate = wrEn && wrUpdate && (wByte_q == `IO_UPDATE_CMD); // R20

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bvalid_q <= 1'b0;
        end else if (doWrite) begin
            bvalid_q <= 1'b1;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Status range takes no writes; those get SLVERR
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            bresp_q <= `RESP_OKAY;
        end else if (doWrite) begin
            if (wrMask || wrClear || wrClearAll || wrUpdate) begin
                bresp_q <= `RESP_OKAY;
            end else begin
                bresp_q <= `RESP_SLVERR; // R21
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////////
    // Event flags, masks and clears

    evt_monitor_pkg::reg8_t evtIn [NUM_EVT];
    evt_monitor_pkg::reg8_t evtValid [NUM_EVT];
    evt_monitor_pkg::reg8_t flags_q [NUM_EVT];
    evt_monitor_pkg::reg8_t mask_q [NUM_EVT];
    evt_monitor_pkg::reg8_t extraMask_q;

    // Bit order of each source matches its register layout
    assign evtIn[0] = clockEvents; // R03 R04 R05
    assign evtIn[1] = loaderEvents; // R06 R07 R08
    assign evtIn[2] = loopEvents; // R09 R10
    assign evtIn[3] = limiterEvents; // R11 R12 R13
    assign evtIn[4] = refAbEvents; // R14
    assign evtIn[5] = refCdEvents; // R14

    assign evtValid[0] = `VALID_CLOCK_EVT; // R03
    assign evtValid[1] = `VALID_LOADER_EVT; // R06
    assign evtValid[2] = `VALID_LOOP_EVT;
    assign evtValid[3] = `VALID_LIMITER_EVT; // R11
    assign evtValid[4] = `VALID_REF_EVT; // R14
    assign evtValid[5] = `VALID_REF_EVT; // R14

    for (genvar k = 0; k < NUM_EVT; k++) begin : g_evt
        logic hitMask;
        logic hitClear;

        assign hitMask = wrEn && (wrIdx == `IDX_MASK_BASE + 12'(k));
        assign hitClear = wrEn && (wrIdx == `IDX_CLEAR_BASE + 12'(k));

        evt_flag_bank #(
            .WIDTH(8)
        ) u_evt_flag_bank (
            .sys_clk(sys_clk),
            .reset(reset),
            .events(evtIn[k]),
            .implBits(evtValid[k]),
            .maskWrite(hitMask),
            .clearWrite(hitClear),
            .clearAll(clearAll),
            .wrByte(wByte_q),
            .maskOut(mask_q[k]),
            .flagsOut(flags_q[k])
        );
    end

    // Last mask slot has no event register behind it; kept for software
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            extraMask_q <= `RST_MASK;
        end else if (wrEn && (wrIdx == `IDX_MASK_LAST)) begin
            extraMask_q <= wByte_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loop status snapshots

    evt_monitor_pkg::reg8_t snap_q;
    evt_monitor_pkg::reg8_t snapTwo_q;
    evt_monitor_pkg::reg8_t snapD;
    evt_monitor_pkg::reg8_t snapTwoD;

    assign snapD = {1'b0, offsetSlewLimited, freqLocked, phaseLocked, // R15
        refSwitching, inHoldover, closedLoopActive, inFreeRun}; // R16
    assign snapTwoD = {2'b00, tuningClamped, historyAvailable, // R17
        activeRefPriority, activeRefIndex}; // R18 R19

    // Sampling only on update keeps both registers coherent for software
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            snap_q <= `RST_SNAP;
            snapTwo_q <= `RST_SNAP;
        end else if (ioUpdate) begin
            snap_q <= snapD; // R20
            snapTwo_q <= snapTwoD; // R20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel

    logic rvalid_q;
    logic [7:0] rByte_q;
    logic [1:0] rresp_q;
    logic arTake;
    evt_monitor_pkg::reg_idx_t rdIdx;
    evt_monitor_pkg::reg8_t rdMux;
    logic rdHit;

    assign s_axi_arready = !rvalid_q;
    assign arTake = s_axi_arvalid && s_axi_arready;
    assign rdIdx = s_axi_araddr[IDX_W+1:2];

    // Reads have no side effect on any flag
    always_comb begin
        rdMux = 8'h00;
        rdHit = 1'b1;
        if (rdIdx >= `IDX_CLOCK_EVT && rdIdx <= `IDX_REF_CD_EVT) begin
            rdMux = flags_q[3'(rdIdx - `IDX_CLOCK_EVT)]; // R02 R21
        end else if (rdIdx >= `IDX_MASK_BASE && rdIdx < `IDX_MASK_LAST) begin
            rdMux = mask_q[3'(rdIdx - `IDX_MASK_BASE)];
        end else if (rdIdx == `IDX_MASK_LAST) begin
            rdMux = extraMask_q;
        end else if (rdIdx == `IDX_LOOP_SNAP) begin
            rdMux = snap_q; // R15 R16
        end else if (rdIdx == `IDX_LOOP_SNAP_TWO) begin
            rdMux = snapTwo_q; // R17
        end else if (rdIdx == `IDX_RSVD_SLOT || rdIdx == `IDX_IO_UPDATE
            || rdIdx == `IDX_CLEAR_ALL) begin
            rdMux = 8'h00;
        end else if (rdIdx >= `IDX_CLEAR_BASE
            && rdIdx < `IDX_CLEAR_BASE + 12'(NUM_EVT)) begin
            rdMux = 8'h00;
        end else begin
            rdHit = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rvalid_q <= 1'b0;
        end else if (arTake) begin
            rvalid_q <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Data held until the next accepted address, so a stalled answer stays put
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rByte_q <= 8'h00;
        end else if (arTake) begin
            rByte_q <= rdMux;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rresp_q <= `RESP_OKAY;
        end else if (arTake) begin
            rresp_q <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = {24'h000000, rByte_q};
    assign s_axi_rresp = rresp_q;

endmodule

////////////////////////////////////////////////////////////////////////
// One event register and its mask, instantiated per event source

module evt_flag_bank #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] events,
    input wire logic [WIDTH-1:0] implBits,
    input wire logic maskWrite,
    input wire logic clearWrite,
    input wire logic clearAll,
    input wire logic [WIDTH-1:0] wrByte,
    output logic [WIDTH-1:0] maskOut,
    output logic [WIDTH-1:0] flagsOut
);

    logic [WIDTH-1:0] mask_q;
    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] clrBits;
    logic [WIDTH-1:0] setBits;

    assign clrBits = (clearWrite ? wrByte : '0) | {WIDTH{clearAll}}; // R02
    assign setBits = events & ~mask_q & implBits; // R01

    // Masking stops new records but leaves a set flag alone
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mask_q <= WIDTH'(`RST_MASK);
        end else if (maskWrite) begin
            mask_q <= wrByte & implBits;
        end
    end

    // Set applied after clear so a coincident event survives
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            flags_q <= WIDTH'(`RST_FLAGS); // R02
        end else begin
            flags_q <= (flags_q & ~clrBits) | setBits; // R01 R02 R22
        end
    end

    assign maskOut = mask_q;
    assign flagsOut = flags_q;

endmodule

`default_nettype wire

// [loop_state_event_flags_status_checker.sv]
// Bus timing checker for the event monitor register port
`timescale 1ns/1ps
`default_nettype none

module loop_state_event_flags_status_checker (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered in one cycle");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed while stalled");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not released");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_no_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer changed while stalled");
    a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted with response pending");
    a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("illegal write response");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_arvalid && s_axi_arready);
    c_read_stall: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind loop_state_event_flags_status loop_state_event_flags_status_checker u_loop_state_event_flags_status_checker (
    .sys_clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

`default_nettype wire

// [loop_state_event_flags_status_bench.sv]
// Self-checking bench for the event monitor
`timescale 1ns/1ps
`default_nettype none

module loop_state_event_flags_status_bench;
    logic sys_clk, reset = 1'b1, awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0;
    logic awR, wR, bV, arR, rV;
    logic [13:0] awA = 14'h0, arA = 14'h0;
    logic [31:0] wD = 32'h0, rD;
    logic [3:0] wS = 4'h0;
    logic [1:0] bResp, rResp;
    logic [7:0] evt [6] = '{default: 8'h00};
    logic [6:0] loopSt = 7'h0;
    logic [5:0] st2 = 6'h0;
    logic [7:0] valid [6] = '{8'h3f, 8'h1f, 8'hff, 8'h1f, 8'h77, 8'h77};
    int errorCnt = 0;
    int nCompared = 0;

    loop_state_event_flags_status #(.ADDR_WIDTH(14)) u_loop_state_event_flags_status (
        .sys_clk(sys_clk), .reset(reset), .s_axi_awvalid(awV), .s_axi_awready(awR),
        .s_axi_awaddr(awA), .s_axi_awprot(3'h0), .s_axi_wvalid(wV), .s_axi_wready(wR),
        .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_bvalid(bV), .s_axi_bready(bRdy),
        .s_axi_bresp(bResp), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_araddr(arA),
        .s_axi_arprot(3'h0), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .s_axi_rdata(rD),
        .s_axi_rresp(rResp), .clockEvents(evt[0]), .loaderEvents(evt[1]),
        .loopEvents(evt[2]), .limiterEvents(evt[3]), .refAbEvents(evt[4]),
        .refCdEvents(evt[5]), .offsetSlewLimited(loopSt[6]), .freqLocked(loopSt[5]),
        .phaseLocked(loopSt[4]), .refSwitching(loopSt[3]), .inHoldover(loopSt[2]),
        .closedLoopActive(loopSt[1]), .inFreeRun(loopSt[0]), .tuningClamped(st2[5]),
        .historyAvailable(st2[4]), .activeRefPriority(st2[3:2]), .activeRefIndex(st2[1:0]));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        nCompared++;
        if (s !== e) begin
            errorCnt++;
            $display("MISMATCH at %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // Ready held low one cycle to exercise the stalled answer
    task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [3:0] s,
            input logic [1:0] er);
        awA <= {i, 2'b00};
        wD <= {24'h0, d};
        wS <= s;
        awV <= 1'b1;
        wV <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (awR) awV <= 1'b0;
            if (wR) wV <= 1'b0;
            if (bV && !bRdy) bRdy <= 1'b1;
        end while (!(bV && bRdy));
        bRdy <= 1'b0;
        chk({30'h0, bResp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] i, input logic [7:0] e, input logic [1:0] er);
        arA <= {i, 2'b00};
        arV <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (arR) arV <= 1'b0;
            if (rV && !rRdy) rRdy <= 1'b1;
        end while (!(rV && rRdy));
        rRdy <= 1'b0;
        chk(rD, {24'h0, e});
        chk({30'h0, rResp}, {30'h0, er});
    endtask

    task automatic pulse(input int k, input logic [7:0] v);
        evt[k] <= v;
        @(posedge sys_clk);
        evt[k] <= 8'h00;
    endtask

    task automatic testDone;
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Whole run is a few hundred cycles; this is ample margin
    initial begin
        repeat (20000) @(posedge sys_clk);
        errorCnt++;
        testDone();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        for (int i = 0; i < 9; i++) rd(12'hd02 + 12'(i), 8'h00, 2'h0);
        for (int k = 0; k < 6; k++) begin
            pulse(k, 8'hff);
            rd(12'hd02 + 12'(k), valid[k], 2'h0);
            rd(12'hd02 + 12'(k), valid[k], 2'h0);
            wr(12'hd02 + 12'(k), 8'h00, 4'hf, 2'h2);
            wr(12'ha04 + 12'(k), 8'hff, 4'h0, 2'h0);
            wr(12'ha04 + 12'(k), 8'h55, 4'hf, 2'h0);
            rd(12'hd02 + 12'(k), valid[k] & 8'haa, 2'h0);
        end
        wr(12'ha03, 8'h02, 4'hf, 2'h0);
        for (int k = 0; k < 6; k++) rd(12'hd02 + 12'(k), 8'h00, 2'h0);
        wr(12'h209, 8'h01, 4'hf, 2'h0);
        pulse(0, 8'h03);
        rd(12'hd02, 8'h02, 2'h0);
        rd(12'h209, 8'h01, 2'h0);
        wr(12'h20f, 8'h5a, 4'hf, 2'h0);
        rd(12'h20f, 8'h5a, 2'h0);
        wr(12'h209, 8'h00, 4'hf, 2'h0);
        // Event lands on the very edge that performs the clear
        fork
            wr(12'ha04, 8'h02, 4'hf, 2'h0);
            begin
                @(posedge sys_clk);
                pulse(0, 8'h02);
            end
        join
        rd(12'hd02, 8'h02, 2'h0);
        for (int k = 0; k < 4; k++) begin
            loopSt <= {k[1:0], k[1:0], k[1:0], k[0]};
            st2 <= {k[1:0], k[1:0], ~k[1:0]};
            wr(12'h005, 8'h01, 4'hf, 2'h0);
            loopSt <= ~loopSt;
            st2 <= ~st2;
            wr(12'h005, 8'h02, 4'hf, 2'h0);
            rd(12'hd08, {1'b0, k[1:0], k[1:0], k[1:0], k[0]}, 2'h0);
            rd(12'hd09, {2'b00, k[1:0], k[1:0], ~k[1:0]}, 2'h0);
        end
        rd(12'h100, 8'h00, 2'h2);
        wr(12'h100, 8'h00, 4'hf, 2'h2);
        pulse(2, 8'h01);
        reset <= 1'b1;
        @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(12'hd04, 8'h00, 2'h0);
        testDone();
    end
endmodule

`default_nettype wire
